// *** jtag_flash_data_port.sv ***
`include "jtag_flash_params.svh"

module jtag_flash_data_port
  import jtag_flash_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tck_i,
  input wire logic tdi_i,
  input wire logic dr_capture_i,
  input wire logic dr_shift_i,
  input wire logic dr_update_i,
  output logic tdo_o,
  input wire logic read_start_en_i,
  input wire logic write_start_en_i,
  output flash_req_s flash_req_o,
  input wire flash_rsp_s flash_rsp_i,
  input wire logic core_halted_i,
  output logic watchdog_run_o,
  output logic periph_run_o,
  output logic [`FDAT_WIDTH-1:0] jtag_flash_data_o
);

  scan_pins_s pins_async;
  scan_pins_s pins_sync;
  logic tck_prev_reg;
  logic tck_rise;
  logic [7:0] flash_byte_field_reg;
  logic fail_reg;
  flash_state_e state_reg;
  logic busy;
  logic [`FDAT_WIDTH-1:0] jtag_flash_data_reg;
  logic [`FDAT_WIDTH-1:0] shift_reg;
  logic start_read;
  logic start_write;

  assign pins_async = '{tck: tck_i, tdi: tdi_i, capture: dr_capture_i,
                        shift: dr_shift_i, update: dr_update_i};

  // the scan pins arrive from the adapter's clock; sample them twice
  bit_sync #(.WIDTH(`SYNC_WIDTH)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pins_async),
    .sync_o(pins_sync)
  );

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      tck_prev_reg <= 1'b0;
    else
      tck_prev_reg <= pins_sync.tck;
  end

  assign tck_rise = pins_sync.tck & ~tck_prev_reg;

  assign busy = (state_reg != ST_IDLE);
  // accesses during busy are quietly dropped rather than queued
  assign start_read = tck_rise & pins_sync.capture & read_start_en_i & ~busy;
  assign start_write = tck_rise & pins_sync.update & write_start_en_i & ~busy;

  always_comb
  begin
    jtag_flash_data_reg = `FDAT_RESET;
    jtag_flash_data_reg[`FDAT_BYTE_MSB:`FDAT_BYTE_LSB] = flash_byte_field_reg;
    jtag_flash_data_reg[`FDAT_FAIL_BIT] = fail_reg;
    jtag_flash_data_reg[`FDAT_BUSY_BIT] = busy;
  end

  // scan shift register, LSB first out on tdo
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      shift_reg <= `FDAT_RESET;
    else if (tck_rise && pins_sync.capture)
      shift_reg <= jtag_flash_data_reg;
    else if (tck_rise && pins_sync.shift)
      shift_reg <= {pins_sync.tdi, shift_reg[`FDAT_WIDTH-1:1]};
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      tdo_o <= 1'b0;
    else
      tdo_o <= shift_reg[0];
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_reg <= ST_IDLE;
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (start_read)
            state_reg <= ST_READ;
          else if (start_write)
            state_reg <= ST_WRITE;
        end
        ST_READ, ST_WRITE:
        begin
          if (flash_rsp_i.ack)
            state_reg <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      flash_byte_field_reg <= 8'h00;
    else if (start_write)
      flash_byte_field_reg <= shift_reg[`FDAT_BYTE_MSB:`FDAT_BYTE_LSB];
    else if (state_reg == ST_READ && flash_rsp_i.ack && !flash_rsp_i.fail)
      flash_byte_field_reg <= flash_rsp_i.rdata;
  end

  // a new operation clears the old verdict; the ack of it sets the new one
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      fail_reg <= 1'b0;
    else if (busy && flash_rsp_i.ack)
      fail_reg <= flash_rsp_i.fail;
    else if (start_read || start_write)
      fail_reg <= 1'b0;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      flash_req_o <= '0;
    else
    begin
      flash_req_o.req <= start_read | start_write;
      flash_req_o.we <= start_write;
      if (start_write)
        flash_req_o.wdata <= shift_reg[`FDAT_BYTE_MSB:`FDAT_BYTE_LSB];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      jtag_flash_data_o <= `FDAT_RESET;
    else
      jtag_flash_data_o <= jtag_flash_data_reg;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      watchdog_run_o <= 1'b0;
    else
      watchdog_run_o <= ~core_halted_i;
  end

  // peripherals never see the halt, so they stay aligned with each other
  assign periph_run_o = 1'b1;

  chk_busy_state: assert property (@(posedge clk_i) disable iff (rst_i)
    flash_req_o.req |=> jtag_flash_data_o[`FDAT_BUSY_BIT])
    else $error("busy bit not shown after request");

  chk_idle_not_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_IDLE) |=> !jtag_flash_data_o[`FDAT_BUSY_BIT])
    else $error("busy shown while idle");

  chk_no_start_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    flash_req_o.req |-> $past(state_reg) == ST_IDLE && state_reg != ST_IDLE)
    else $error("flash request issued while busy");

  chk_read_byte: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_READ && flash_rsp_i.ack && !flash_rsp_i.fail) |=>
      ##1 jtag_flash_data_o[`FDAT_BYTE_MSB:`FDAT_BYTE_LSB] == $past(flash_rsp_i.rdata, 2))
    else $error("read byte not placed in bits 9..2");

  chk_write_byte: assert property (@(posedge clk_i) disable iff (rst_i)
    start_write |=> flash_req_o.we && flash_req_o.wdata == flash_byte_field_reg)
    else $error("write byte mismatch");

  chk_fail_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (busy && flash_rsp_i.ack) |=> ##1 jtag_flash_data_o[`FDAT_FAIL_BIT] == $past(flash_rsp_i.fail, 2))
    else $error("failure bit not reported");

  chk_wdt_halt: assert property (@(posedge clk_i) disable iff (rst_i)
    core_halted_i |=> !watchdog_run_o)
    else $error("watchdog running during halt");

  chk_periph_run: assert property (@(posedge clk_i) disable iff (rst_i)
    core_halted_i |-> periph_run_o)
    else $error("peripherals stopped during halt");

  chk_reset_zero: assert property (@(posedge clk_i)
    $fell(rst_i) |-> jtag_flash_data_o == `FDAT_RESET)
    else $error("data register not zero after reset");

  cov_read: cover property (@(posedge clk_i) disable iff (rst_i)
    start_read ##[1:300] (state_reg == ST_READ && flash_rsp_i.ack));
  cov_write: cover property (@(posedge clk_i) disable iff (rst_i)
    start_write ##[1:300] (state_reg == ST_WRITE && flash_rsp_i.ack));
  cov_fail: cover property (@(posedge clk_i) disable iff (rst_i)
    busy && flash_rsp_i.ack && flash_rsp_i.fail);
  cov_busy_drop: cover property (@(posedge clk_i) disable iff (rst_i)
    busy && tck_rise && pins_sync.update && write_start_en_i);

endmodule

// *** jtag_flash_params.svh ***
`ifndef JTAG_FLASH_PARAMS_SVH
`define JTAG_FLASH_PARAMS_SVH

`define FDAT_WIDTH 10
`define FDAT_BYTE_MSB 9
`define FDAT_BYTE_LSB 2
`define FDAT_FAIL_BIT 1
`define FDAT_BUSY_BIT 0
`define FDAT_RESET 10'h000
`define SYNC_WIDTH 5

`endif

// *** jtag_flash_pkg.sv ***
package jtag_flash_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } flash_state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] wdata;
  } flash_req_s;

  typedef struct packed {
    logic ack;
    logic fail;
    logic [7:0] rdata;
  } flash_rsp_s;

  typedef struct packed {
    logic tck;
    logic tdi;
    logic capture;
    logic shift;
    logic update;
  } scan_pins_s;

endpackage

// *** bit_sync.sv ***
module bit_sync
  import jtag_flash_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          meta_reg[g] <= 1'b0;
          sync_o[g] <= 1'b0;
        end
        else
        begin
          meta_reg[g] <= async_i[g];
          sync_o[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

endmodule

// *** flash_model.sv ***
module flash_model
  import jtag_flash_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire flash_req_s req_i,
  input wire logic [7:0] delay_i,
  input wire logic fail_i,
  output flash_rsp_s rsp_o
);
  logic [7:0] mem_reg;
  logic [7:0] cnt_reg;
  logic we_reg;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mem_reg <= 8'h00;
      cnt_reg <= 8'h00;
      we_reg <= 1'b0;
      rsp_o <= '0;
    end
    else
    begin
      rsp_o.ack <= 1'b0;
      // no valid byte outside ack, so keep it moving
      rsp_o.rdata <= ~rsp_o.rdata;
      if (req_i.req)
      begin
        cnt_reg <= delay_i;
        we_reg <= req_i.we;
      end
      else if (cnt_reg != 8'h00)
      begin
        cnt_reg <= cnt_reg - 8'h01;
        if (cnt_reg == 8'h01)
        begin
          rsp_o.ack <= 1'b1;
          rsp_o.fail <= fail_i;
          rsp_o.rdata <= mem_reg;
          // locked location: write is dropped
          if (we_reg && !fail_i)
            mem_reg <= req_i.wdata;
        end
      end
    end
  end
endmodule

// *** jtag_flash_data_port_test.sv ***
`include "jtag_flash_params.svh"
module jtag_flash_data_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  import jtag_flash_pkg::*;
  logic clk_i = 0, rst_i = 1, tck_i = 0, tdi_i = 0, cap = 0, sh = 0, up = 0;
  logic rd_en = 0, wr_en = 0, halt = 0, fl_fail = 0, tdo, wd, pr, tdo_seen, we_seen, wf, rf;
  logic [7:0] dly = 8'hC8, wd_seen, mem_exp, reg_exp, d;
  logic [9:0] dat, dout;
  flash_req_s req;
  flash_rsp_s rsp;
  int bad_count = 0, checked = 0, seed = 28, nreq = 0, n0;

  jtag_flash_data_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .tck_i(tck_i), .tdi_i(tdi_i),
    .dr_capture_i(cap), .dr_shift_i(sh), .dr_update_i(up), .tdo_o(tdo),
    .read_start_en_i(rd_en), .write_start_en_i(wr_en), .flash_req_o(req),
    .flash_rsp_i(rsp), .core_halted_i(halt), .watchdog_run_o(wd), .periph_run_o(pr),
    .jtag_flash_data_o(dat));
  flash_model u_flash (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .delay_i(dly),
    .fail_i(fl_fail), .rsp_o(rsp));

  initial forever #2.5 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    if (req.req === 1'b1)
    begin
      nreq <= nreq + 1;
      wd_seen <= req.wdata;
      we_seen <= req.we;
    end
  end

  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // register layout: byte in 9..2, failure in 1, busy in 0
  function automatic logic [9:0] exp_reg(input logic [7:0] b, input logic f, input logic bz);
    exp_reg = {b, f, bz};
  endfunction

  // one link clock period, about 65 ns, low half first
  task automatic tick(input logic c, s, u, t);
    tck_i <= 1'b0;
    cap <= c;
    sh <= s;
    up <= u;
    tdi_i <= t;
    repeat (7) @(posedge clk_i);
    tdo_seen = tdo;
    tck_i <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic scan(input logic c, u, input logic [9:0] din);
    tick(c, 0, 0, 0);
    for (int i = 0; i < 10; i++)
    begin
      tick(0, 1, 0, din[i]);
      dout[i] = tdo_seen;
    end
    tick(0, 0, u, 0);
  endtask

  task automatic wait_idle;
    int n = 0;
    while (dat[0] !== 1'b0 && n < 600)
    begin
      @(posedge clk_i);
      n++;
    end
    check(10'(n < 600), 10'h001);
    repeat (3) @(posedge clk_i);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #200000;
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(dat, `FDAT_RESET);
    check(10'(pr), 10'h001);
    mem_exp = 8'h00;
    reg_exp = 8'h00;
    for (int k = 0; k < 8; k++)
    begin
      // first pass: all-ones byte, clean write
      d = (k == 0) ? 8'hFF : 8'($random(seed));
      wf = (k > 0) & 1'($random(seed));
      rf = (k > 1) & 1'($random(seed));
      halt <= 1'($random(seed));
      dly <= 8'd180 + 8'($random(seed) & 63);
      fl_fail <= wf;
      wr_en <= 1'b1;
      rd_en <= 1'b0;
      n0 = nreq;
      scan(0, 1, {d, 2'b00});
      check(10'(dat[0]), 10'h001);
      check(10'(nreq), 10'(n0 + 1));
      check(10'(wd_seen), 10'(d));
      check(10'(we_seen), 10'h001);
      check(10'(wd), 10'(!halt));
      // read and write both refused while busy; the capture shows busy set
      rd_en <= 1'b1;
      scan(1, 1, ~{d, 2'b00});
      check(dout, exp_reg(d, 1'b0, 1'b1));
      check(10'(nreq), 10'(n0 + 1));
      wait_idle();
      check(dat, exp_reg(d, wf, 1'b0));
      if (!wf)
        mem_exp = d;
      // the written byte stays in the register until a good read replaces it
      reg_exp = d;
      fl_fail <= rf;
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      scan(1, 0, 10'h000);
      rd_en <= 1'b0;
      check(dout, exp_reg(d, wf, 1'b0));
      check(10'(dat[0]), 10'h001);
      check(10'(nreq), 10'(n0 + 2));
      check(10'(we_seen), 10'h000);
      wait_idle();
      if (!rf)
        reg_exp = mem_exp;
      check(dat, exp_reg(reg_exp, rf, 1'b0));
      scan(1, 0, 10'h000);
      check(dout, exp_reg(reg_exp, rf, 1'b0));
    end
    tally_and_finish();
  end
endmodule
